// *** src/hbm_cfg.svh ***
// Constants for the 16-bit multiplexed host-bus port.
// Included by the port alone; the phase timer does not use it; definitions only.
`ifndef HBM_CFG_SVH
`define HBM_CFG_SVH

// Interface mode field value that selects 16-bit host-bus operation
`define HBM_IF_MODE_HOST16   4'h3
// Host16 mode field value that selects multiplexed address/data
`define HBM_HOST16_MUXED     2'h0

// Select line config field encodings
`define HBM_SELECT_LINE_CONFIG_FIELD_ALE        3'h0
`define HBM_SELECT_LINE_CONFIG_FIELD_ONE        3'h1
`define HBM_SELECT_LINE_CONFIG_FIELD_TWO        3'h2
`define HBM_SELECT_LINE_CONFIG_FIELD_ALE_TWO    3'h3
`define HBM_SELECT_LINE_CONFIG_FIELD_ALE_FOUR   3'h4

// Idle level of the active-low pins
`define HBM_CS_IDLE          4'hF
`define HBM_BYTE_LANE_SELECTS_IDLE        2'h3

// Bus timing: least phase time and the clock period
`define HBM_PHASE_NS         20
`define HBM_CLK_NS           5

`endif

// *** src/hbm_pkg.sv ***
// Types shared by the 16-bit multiplexed host-bus port.
// No surroundings assumed.
package hbm_pkg;

   // Bus cycle sequencer states
   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_hold,
      st_data,
      st_recover
   } hbm_state_e;

endpackage

// *** src/hbm_phase_timer.sv ***
// Phase timer for the host-bus sequencer.
// Assumes load and len come from logic on ref_clk.
`timescale 1ns/100ps
`default_nettype none

module hbm_phase_timer #(
   parameter int W = 8
) (
   // Clock, reset, enable
   input  wire logic         ref_clk,
   input  wire logic         rst_q_n,
   input  wire logic         ce,
   // Control
   input  wire logic         load,
   input  wire logic [W-1:0] len,
   output logic              expired
);

   logic [W-1:0] cnt;

   // Counts len cycles down to zero; len of zero behaves as one
   always_ff @(posedge ref_clk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         cnt <= '0;
      end else if (ce) begin
         if (load)
            cnt <= (len == '0) ? '0 : len - 1'b1;
         else if (cnt != '0)
            cnt <= cnt - 1'b1;
      end
   end

   assign expired = (cnt == '0);

endmodule // hbm_phase_timer

`default_nettype wire

// *** src/hbm_port.sv ***
// 16-bit host-bus port, multiplexed address/data variant, device side.
// Assumes config and request inputs on ref_clk; ad_in comes from pins.
`timescale 1ns/100ps
`default_nettype none
`include "hbm_cfg.svh"

// Functional notes
// RULE1: The port runs bus cycles only while the interface mode field selects 16-bit host bus.
// RULE2: In that mode, the host16 fields pick muxing, byte-lane selects and select lines.
// RULE3: Each bus phase is stretched to a slow least time so older logic keeps up.
// RULE4: The multiplexed variant is chosen by the host16 mode field alone.
// RULE5: Address goes out on the same pins that later carry the low data half.
// RULE6: Sharing pins leaves the upper lines free, giving a wider address.
// RULE7: A latch strobe makes the outside latch grab the address, held through data.
// RULE8: Reads use a read strobe and writes a write strobe for the data phase.
// RULE9: One to four chip selects are driven, as configured.
// RULE10: With byte-lane selects on, two selects pick the lower or upper half.
// RULE11: The byte-select field decides whether byte-lane selects are used.
// RULE12: The select line config field decides latch strobe and chip-select presence.
// RULE13: Field codes 0 latch only, 1 one select, 2 two selects, 3 latch plus two.
// RULE14: Address and latch strobe come before the read or write strobe, then data.
// RULE15: Only the chip select of the addressed region goes active.
module hbm_port #(
   parameter int ADDR_W = 28,
   parameter int WAIT_W = 4
) (
   // Clock, reset, enable
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   // Configuration
   input  wire logic [3:0]        if_mode,
   input  wire logic [1:0]        host16_mode,
   input  wire logic              byte_sel_en,
   input  wire logic [2:0]        cs_cfg,
   input  wire logic [WAIT_W-1:0] wait_states,
   // Request and answer
   input  wire logic              req_valid,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [15:0]       req_wdata,
   input  wire logic [1:0]        req_be,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic [15:0]            rsp_rdata,
   // Bus pins
   input  wire logic [15:0]       ad_in,
   output logic [15:0]            ad_out,
   output logic                   ad_oe,
   output logic [ADDR_W-17:0]     addr_hi,
   output logic                   ale,
   output logic                   rd_n,
   output logic                   wr_n,
   output logic [3:0]             cs_n,
   output logic [1:0]             byte_lane_selects_n
);

   localparam logic [7:0] PHASE_CYC =
      8'((`HBM_PHASE_NS + `HBM_CLK_NS - 1) / `HBM_CLK_NS);

   // Select line decode by config and the top two address bits
   function automatic logic [3:0] cs_decode(input logic [2:0] cfg, input logic [1:0] top);
      logic [3:0] sel;
      sel = 4'h0;
      case (cfg) // RULE13
         `HBM_SELECT_LINE_CONFIG_FIELD_ONE:                     sel = 4'h1;
         `HBM_SELECT_LINE_CONFIG_FIELD_TWO, `HBM_SELECT_LINE_CONFIG_FIELD_ALE_TWO: sel = top[1] ? 4'h2 : 4'h1;
         `HBM_SELECT_LINE_CONFIG_FIELD_ALE_FOUR:                sel = 4'h1 << top;
         default:                            sel = 4'h0;
      endcase
      return sel;
   endfunction

   logic [1:0]          rst_pipe;
   logic                rst_q_n;
   logic [15:0]         ad_meta;
   logic [15:0]         ad_sync;
   hbm_pkg::hbm_state_e state;
   hbm_pkg::hbm_state_e next_state;
   logic                wr_q;
   logic                byte_lane_selects_q;
   logic [2:0]          cfg_q;
   logic [ADDR_W-1:0]   addr_q;
   logic [15:0]         wdata_q;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         rst_pipe <= 2'h0;
      else
         rst_pipe <= {rst_pipe[0], 1'b1};
   end
   assign rst_q_n = rst_pipe[1];

   // Pin data synchroniser; only ad_sync is read by logic
   always_ff @(posedge ref_clk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         ad_meta <= 16'h0000;
         ad_sync <= 16'h0000;
      end else if (ce) begin
         ad_meta <= ad_in;
         ad_sync <= ad_meta;
      end
   end

   // Mode gate and sequencer strobes
   wire       mode_ok   = (if_mode == `HBM_IF_MODE_HOST16)    // RULE1
                       && (host16_mode == `HBM_HOST16_MUXED); // RULE4
   wire       expired;
   // Mode also gates the take itself, so a mode drop in the ready cycle refuses
   wire       accept    = (state == hbm_pkg::st_idle) && req_valid && req_ready
                       && mode_ok; // RULE1
   wire       adv       = (state != hbm_pkg::st_idle) && expired;
   wire       to_data   = adv && (state == hbm_pkg::st_hold);
   wire       data_end  = adv && (state == hbm_pkg::st_data);
   wire       cyc_end   = adv && (state == hbm_pkg::st_recover);
   wire       ale_avail = (cs_cfg == `HBM_SELECT_LINE_CONFIG_FIELD_ALE) || (cs_cfg == `HBM_SELECT_LINE_CONFIG_FIELD_ALE_TWO)
                       || (cs_cfg == `HBM_SELECT_LINE_CONFIG_FIELD_ALE_FOUR); // RULE12
   wire [1:0] region    = req_addr[ADDR_W-1 -: 2];

   // Strobe phase carries the extra wait states; others take the base time
   wire       tmr_load  = accept || (adv && !cyc_end);
   wire [7:0] tmr_len   = to_data ? PHASE_CYC + 8'(wait_states) : PHASE_CYC; // RULE3

   // Sequencer: address, latch hold, strobe, recovery
   always_comb begin
      next_state = state;
      unique case (state)
         hbm_pkg::st_idle:    if (accept) next_state = hbm_pkg::st_addr;
         hbm_pkg::st_addr:    if (adv) next_state = hbm_pkg::st_hold;
         hbm_pkg::st_hold:    if (adv) next_state = hbm_pkg::st_data;
         hbm_pkg::st_data:    if (adv) next_state = hbm_pkg::st_recover;
         hbm_pkg::st_recover: if (adv) next_state = hbm_pkg::st_idle;
      endcase
   end

   // Next values of the pin and answer registers
   wire [15:0]       next_ad_out   = accept  ? req_addr[15:0]          // RULE5
                                   : (to_data && wr_q) ? wdata_q : ad_out;
   wire              next_ad_oe    = accept ? 1'b1 : to_data ? wr_q    // RULE14
                                   : cyc_end ? 1'b0 : ad_oe;
   wire [ADDR_W-17:0] next_addr_hi = accept ? req_addr[ADDR_W-1:16] : addr_hi; // RULE6
   wire              next_ale      = accept ? ale_avail                // RULE7
                                   : (adv && state == hbm_pkg::st_addr) ? 1'b0 : ale;
   wire              next_rd_n     = (to_data && !wr_q) ? 1'b0 : data_end ? 1'b1 : rd_n; // RULE8
   wire              next_wr_n     = (to_data && wr_q) ? 1'b0 : data_end ? 1'b1 : wr_n;
   wire [3:0]        next_cs_n     = accept ? ~cs_decode(cs_cfg, region) // RULE9
                                   : cyc_end ? `HBM_CS_IDLE : cs_n;     // RULE15
   wire [1:0]        next_byte_lane_selects_n   = accept ? (byte_sel_en ? ~req_be : `HBM_BYTE_LANE_SELECTS_IDLE) // RULE10
                                   : cyc_end ? `HBM_BYTE_LANE_SELECTS_IDLE : byte_lane_selects_n; // RULE11
   wire [15:0]       next_rsp_rdata = (data_end && !wr_q) ? ad_sync : rsp_rdata;
   wire              next_req_ready = mode_ok && (next_state == hbm_pkg::st_idle); // RULE2

   hbm_phase_timer #(
      .W (8)
   ) u_timer (
      .ref_clk (ref_clk),
      .rst_q_n (rst_q_n),
      .ce      (ce),
      .load    (tmr_load),
      .len     (tmr_len),
      .expired (expired)
   );

   // Request capture, held for the whole bus cycle
   always_ff @(posedge ref_clk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         wr_q    <= 1'b0;
         byte_lane_selects_q  <= 1'b0;
         cfg_q   <= 3'h0;
         addr_q  <= '0;
         wdata_q <= 16'h0000;
      end else if (ce && accept) begin
         wr_q    <= req_write;
         byte_lane_selects_q  <= byte_sel_en;
         cfg_q   <= cs_cfg; // RULE13
         addr_q  <= req_addr;
         wdata_q <= req_wdata;
      end
   end

   // State and output registers
   always_ff @(posedge ref_clk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         state     <= hbm_pkg::st_idle;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 16'h0000;
         ad_out    <= 16'h0000;
         ad_oe     <= 1'b0;
         addr_hi   <= '0;
         ale       <= 1'b0;
         rd_n      <= 1'b1;
         wr_n      <= 1'b1;
         cs_n      <= `HBM_CS_IDLE;
         byte_lane_selects_n    <= `HBM_BYTE_LANE_SELECTS_IDLE;
      end else if (ce) begin
         state     <= next_state;
         req_ready <= next_req_ready;
         rsp_valid <= data_end;
         rsp_rdata <= next_rsp_rdata;
         ad_out    <= next_ad_out;
         ad_oe     <= next_ad_oe;
         addr_hi   <= next_addr_hi;
         ale       <= next_ale;
         rd_n      <= next_rd_n;
         wr_n      <= next_wr_n;
         cs_n      <= next_cs_n;
         byte_lane_selects_n    <= next_byte_lane_selects_n;
      end
   end

   // Checks on the driven pins and answers
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_q_n);

   a_ready_mode: // RULE1
   assert property (req_ready && $past(ce) |-> $past(mode_ok))
      else $error("ready raised outside muxed host16 mode");

   a_ale_width: // RULE3
   assert property ($rose(ale) |-> ale [*4])
      else $error("latch strobe shorter than the phase time");

   a_addr_out: // RULE6
   assert property ($rose(ale) |-> {addr_hi, ad_out} == addr_q)
      else $error("address pins differ from the accepted address");

   a_ale_drive: // RULE7
   assert property (ale |-> ad_oe && rd_n && wr_n)
      else $error("latch strobe without address on the pins");

   a_strobe_order: // RULE14
   assert property (($fell(rd_n) || $fell(wr_n)) |-> !ale && $past(ad_oe) && !$past(ale))
      else $error("strobe before the address phase closed");

   a_read_float: // RULE8
   assert property (!rd_n |-> !ad_oe && wr_n)
      else $error("pins driven during a read strobe");

   a_write_data: // RULE5
   assert property (!wr_n |-> ad_oe && ad_out == wdata_q)
      else $error("write data missing on the shared pins");

   a_read_answer: // RULE8
   assert property (rsp_valid |-> (!$past(rd_n) || !$past(wr_n))
                    && (wr_q || rsp_rdata == $past(ad_sync)))
      else $error("answer not tied to the strobe end");

   a_cs_match: // RULE15
   assert property (cs_n != `HBM_CS_IDLE |->
                    $onehot(~cs_n) && ~cs_n == cs_decode(cfg_q, addr_q[ADDR_W-1 -: 2]))
      else $error("wrong or extra chip select active");

   a_byte_lane_selects_gate: // RULE11
   assert property (byte_lane_selects_n != `HBM_BYTE_LANE_SELECTS_IDLE |-> byte_lane_selects_q && state != hbm_pkg::st_idle)
      else $error("byte-lane select while disabled or idle");

endmodule // hbm_port

`default_nettype wire

// *** testbench/hbm_latch_model.sv ***
// Far-side model: address latch plus read data made from the latched address.
// Assumes it sees the port's pins on ref_clk; ad_in goes back to the port.
`timescale 1ns/100ps
`default_nettype none

module hbm_latch_model (
   // Clock
   input  wire logic        ref_clk,
   // Pins from the port
   input  wire logic        ale,
   input  wire logic [15:0] ad_out,
   input  wire logic        ad_oe,
   input  wire logic        rd_n,
   // Pins back to the port, latched address
   output logic [15:0]      ad_in,
   output logic [15:0]      latched
);
   initial begin
      ad_in = 16'h0000;
      latched = 16'h0000;
   end

   // Latch follows the shared lines while the strobe is high, then holds
   always @(posedge ref_clk) begin
      if (ale && ad_oe) latched <= ad_out;
   end

   // Read data comes from the latched address; an idle bus toggles so stale data never matches
   always @(posedge ref_clk) begin
      ad_in <= !rd_n ? (latched ^ 16'h5A5A) : ~ad_in;
   end
endmodule // hbm_latch_model

`default_nettype wire

// *** testbench/test_host_bus16_muxed_port.sv ***
// Self-checking bench for the muxed host-bus port.
// Assumes the far-side latch model; no bus, config bits are plain ports.
`timescale 1ns/100ps
`default_nettype none

module test_host_bus16_muxed_port;
   localparam int AW = 28;
   logic          ref_clk, rst_n, ce, byte_sel_en, req_valid, req_write;
   logic [3:0]    if_mode, wait_states, cs_n;
   logic [1:0]    host16_mode, req_be, byte_lane_selects_n;
   logic [2:0]    cs_cfg;
   logic [AW-1:0] req_addr;
   logic [15:0]   req_wdata, rsp_rdata, ad_in, ad_out, latched;
   logic [AW-17:0] addr_hi;
   logic          req_ready, rsp_valid, ad_oe, ale, rd_n, wr_n;
   int            mismatches, checks_done, c;

   hbm_port #(.ADDR_W(AW), .WAIT_W(4)) hbm_port_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .if_mode(if_mode),
      .host16_mode(host16_mode), .byte_sel_en(byte_sel_en), .cs_cfg(cs_cfg),
      .wait_states(wait_states), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ad_in(ad_in), .ad_out(ad_out),
      .ad_oe(ad_oe), .addr_hi(addr_hi), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
      .cs_n(cs_n), .byte_lane_selects_n(byte_lane_selects_n));

   hbm_latch_model hbm_latch_model_inst (
      .ref_clk(ref_clk), .ale(ale), .ad_out(ad_out), .ad_oe(ad_oe), .rd_n(rd_n),
      .ad_in(ad_in), .latched(latched));

   // Free-running 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // Expected select lines, worked out from the field code and top address bits
   function automatic logic [3:0] exp_cs(input logic [2:0] cfg, input logic [AW-1:0] a);
      case (cfg)
         3'h1: return 4'hE;
         3'h2, 3'h3: return a[AW-1] ? 4'hD : 4'hE;
         3'h4: return ~(4'h1 << a[AW-1:AW-2]);
         default: return 4'hF;
      endcase
   endfunction

   // Mode change, then the ready flag once it has settled
   task automatic set_mode(input logic [3:0] m, input logic [1:0] h, input logic exp);
      @(posedge ref_clk);
      if_mode <= m;
      host16_mode <= h;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      check(req_ready, exp);
   endtask

   // One bus cycle, pins sampled mid-cycle so edge updates have landed
   task automatic access(input logic wr, input logic [AW-1:0] a, input logic [15:0] d,
                         input logic [1:0] be, input logic [2:0] cfg, input logic bs,
                         input logic [3:0] ws);
      int n, lat, sf, al;
      logic [15:0] a0, wd;
      logic [11:0] hi;
      logic [3:0] cs;
      logic [1:0] bsl;
      logic wk, rk, oe0, oes;
      lat = -1;
      sf = -1;
      al = -1;
      for (n = 0; n < 100; n++) begin
         @(negedge ref_clk);
         if (req_ready === 1'b1) break;
      end
      if (n == 100) begin
         mismatches++;
         give_verdict;
      end
      // Idle pins while ready: nothing selected, lines released
      check(cs_n, 4'hF);
      check(ad_oe, 1'b0);
      check(byte_lane_selects_n, 2'h3);
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= d;
      req_be <= be;
      cs_cfg <= cfg;
      byte_sel_en <= bs;
      wait_states <= ws;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      for (n = 0; n < 100 && lat < 0; n++) begin
         @(negedge ref_clk);
         if (n == 0) begin
            a0 = ad_out;
            hi = addr_hi;
            oe0 = ad_oe;
         end
         if (ale === 1'b1) al = n;
         if (sf < 0 && (rd_n === 1'b0 || wr_n === 1'b0)) begin
            sf = n;
            cs = cs_n;
            bsl = byte_lane_selects_n;
            wd = ad_out;
            wk = wr_n;
            rk = rd_n;
            oes = ad_oe;
         end
         if (rsp_valid === 1'b1) lat = n;
      end
      if (lat < 0) begin
         mismatches++;
         give_verdict;
      end
      check(a0, a[15:0]);
      check(hi, a[AW-1:16]);
      check(oe0, 1'b1);
      check(oes, wr);
      check(rk, wr);
      check(al >= 0, cfg == 3'h0 || cfg == 3'h3 || cfg == 3'h4);
      check(al < sf, 1'b1);
      check(sf, 8);
      check(lat, 12 + ws);
      check(cs, exp_cs(cfg, a));
      check(bsl, bs ? 2'(~be) : 2'h3);
      check(wk, !wr);
      if (wr) begin
         check(wd, d);
      end else begin
         check(rsp_rdata, a[15:0] ^ 16'h5A5A);
         check(latched, a[15:0]);
      end
   endtask

   // Main sequence: refusals, every select code, byte lanes, wait states
   initial begin
      mismatches = 0;
      checks_done = 0;
      rst_n = 1'b0;
      ce = 1'b1;
      if_mode = 4'h3;
      host16_mode = 2'h0;
      byte_sel_en = 1'b0;
      cs_cfg = 3'h0;
      wait_states = 4'h0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = '0;
      req_wdata = 16'h0000;
      req_be = 2'h3;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      set_mode(4'h2, 2'h0, 1'b0);
      set_mode(4'h3, 2'h1, 1'b0);
      set_mode(4'h3, 2'h0, 1'b1);
      for (c = 0; c < 5; c++) begin
         access(c == 1 || c == 2, {2'(c + 1), 10'h000, 16'h1234 + 16'(c)},
                16'hC3A0 + 16'(c), 2'h3, 3'(c), 1'b0, 4'h0);
      end
      access(1'b1, 28'h0ABCDEF, 16'hBEEF, 2'h1, 3'h3, 1'b1, 4'h0);
      access(1'b1, 28'h8001357, 16'h7E81, 2'h2, 3'h3, 1'b1, 4'h3);
      access(1'b0, 28'h4002468, 16'h0000, 2'h2, 3'h4, 1'b1, 4'h1);
      // Enable low freezes the port: a waiting request is not taken
      repeat (8) @(posedge ref_clk);
      ce <= 1'b0;
      req_valid <= 1'b1;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      check(req_ready, 1'b1);
      check(cs_n, 4'hF);
      @(posedge ref_clk);
      req_valid <= 1'b0;
      ce <= 1'b1;
      // Unused select code: no latch strobe, no chip select
      access(1'b1, 28'h3000ABC, 16'h55AA, 2'h2, 3'h5, 1'b1, 4'h0);
      give_verdict;
   end
endmodule // test_host_bus16_muxed_port

`default_nettype wire
